// >>> hw/ebcit_timing.sv
// Instruction decode and cycle timing control for the pipelined 8-bit core.
// Assumes an opcode is offered with op_valid and branch outcome given at op time.
// Operation
// (RL1) Timing counted only in system clocks, no machine cycles.
// (RL2) Opcode encodings and flag effects follow the reference instruction set.
// (RL3) Most instructions take as many clocks as program bytes.
// (RL4) Conditional branch not taken finishes one clock sooner than taken.
// (RL5) Accumulator ALU operations with indirect RAM take two clocks.
// (RL6) Subtract bank register with borrow: one byte, one clock.
// (RL7) Logic immediate into direct byte: three bytes, three clocks.
// (RL8) Data pointer increment: one byte, one clock.
// (RL9) Rotate accumulator through carry: one byte, one clock.
// (RL10) Direct to direct move: three bytes, three clocks.
// (RL11) Immediate to indirect RAM: two bytes, two clocks.
// (RL12) Load data pointer immediate: three bytes, three clocks.
// (RL13) Code byte moves: one byte, three clocks.
// (RL14) External data moves, both address forms: one byte, three clocks.
// (RL15) Push direct: two bytes, two clocks.
// (RL16) Pop direct: two bytes, two clocks.
// (RL17) Low nibble exchange with indirect RAM: one byte, two clocks.
// (RL18) Complement, set or clear direct bit: two bytes, two clocks.
// (RL19) Combine direct bit into carry: two bytes, two clocks.
// (RL20) No instruction exceeds eight clocks.
// (RL21) Multiply takes four clocks, divide eight; both one byte.
`timescale 1ns/10ps
`include "ebcit_consts.svh"
module ebcit_timing #(
  parameter int CYC_W = `EBCIT_CYC_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire logic [7:0] opcode,
  input wire logic branch_taken,
  output logic op_ready,
  output logic busy,
  output logic instr_done,
  output logic [1:0] instr_bytes,
  output logic [CYC_W-1:0] instr_cycles,
  output logic [CYC_W-1:0] cycle_index,
  output logic external_data_move,
  output logic code_byte_move
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [1:0] len;
  logic [CYC_W-1:0] cyc_d;
  ebcit_pkg::ebcit_class_e cls_d;
  logic [3:0] lo;
  logic [3:0] hi;
  assign lo = opcode[3:0];
  assign hi = opcode[7:4];

  // Same byte lengths as the reference encoding.
  // (RL2) reference byte lengths
  ebcit_length ebcit_length_i (
    .opcode(opcode),
    .length(len)
  );

  always_comb begin
    // (RL3) cycles equal bytes
    // (RL6) register subtract one clock
    // (RL7) logic immediate direct
    // (RL8) pointer increment one clock
    // (RL9) carry rotate one clock
    // (RL10) direct to direct
    // (RL12) pointer load immediate
    // (RL15) push direct byte
    // (RL16) pop direct byte
    // (RL18) direct bit update
    // (RL19) bit into carry
    cyc_d = CYC_W'(len);
    cls_d = ebcit_pkg::EBCIT_CLS_PLAIN;
    // (RL5) indirect ALU two clocks
    // (RL17) nibble exchange two clocks
    if ((lo == 4'h6 || lo == 4'h7) && hi != 4'h7 && hi != 4'h8 && hi != 4'ha
        && hi != 4'hb) begin
      cyc_d = `EBCIT_CYC_IND;
    end
    // (RL11) immediate to indirect
    if (opcode == 8'h76 || opcode == 8'h77) begin
      cyc_d = `EBCIT_CYC_IND;
    end
    // (RL14) external data three clocks
    if (opcode == 8'he0 || opcode == 8'he2 || opcode == 8'he3 || opcode == 8'hf0
        || opcode == 8'hf2 || opcode == 8'hf3) begin
      cyc_d = `EBCIT_CYC_XDATA;
      cls_d = ebcit_pkg::EBCIT_CLS_XDATA;
    end
    // (RL13) code byte three clocks
    if (opcode == 8'h93 || opcode == 8'h83) begin
      cyc_d = `EBCIT_CYC_CODE;
      cls_d = ebcit_pkg::EBCIT_CLS_CODE;
    end
    // (RL21) multiply and divide
    if (opcode == 8'ha4) begin
      cyc_d = `EBCIT_CYC_MUL;
      cls_d = ebcit_pkg::EBCIT_CLS_MULDIV;
    end
    if (opcode == 8'h84) begin
      cyc_d = `EBCIT_CYC_DIV;
      cls_d = ebcit_pkg::EBCIT_CLS_MULDIV;
    end
    // Unconditional jumps and calls take one more clock than bytes.
    if (lo == 4'h1 || opcode == 8'h02 || opcode == 8'h12 || opcode == 8'h80
        || opcode == 8'h73) begin
      cyc_d = CYC_W'(len) + CYC_W'(1);
      cls_d = ebcit_pkg::EBCIT_CLS_JUMP;
    end
    if (opcode == 8'h22 || opcode == 8'h32) begin
      cyc_d = `EBCIT_CYC_RET;
      cls_d = ebcit_pkg::EBCIT_CLS_JUMP;
    end
    // (RL4) taken branch adds one
    if (opcode == 8'h10 || opcode == 8'h20 || opcode == 8'h30 || opcode == 8'h40
        || opcode == 8'h50 || opcode == 8'h60 || opcode == 8'h70 || opcode == 8'hd5
        || (hi == 4'hb && lo >= 4'h4) || (hi == 4'hd && lo >= 4'h8)) begin
      cls_d = ebcit_pkg::EBCIT_CLS_COND;
      cyc_d = CYC_W'(len);
      if (opcode == 8'hb6 || opcode == 8'hb7) begin
        cyc_d = CYC_W'(len) + CYC_W'(1);
      end
      if (branch_taken) begin
        cyc_d = cyc_d + CYC_W'(1);
      end
    end
    // (RL20) cap at eight clocks
    if (cyc_d > `EBCIT_CYC_MAX) begin
      cyc_d = `EBCIT_CYC_MAX;
    end
  end

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  ebcit_pkg::ebcit_state_e state_q;
  ebcit_pkg::ebcit_state_e state_d;
  logic last;
  logic take;
  // Ready only once execute is left, so an N-clock instruction spaces the next by N clocks.
  assign op_ready = (state_q != ebcit_pkg::EBCIT_EXEC);
  assign take = op_valid && op_ready;

  // (RL1) counted in clocks
  ebcit_counter #(
    .CYC_W(CYC_W)
  ) ebcit_counter_i (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .load(take),
    .cycles(cyc_d),
    .last(last)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      ebcit_pkg::EBCIT_IDLE: begin
        if (take && cyc_d != CYC_W'(1)) begin
          state_d = ebcit_pkg::EBCIT_EXEC;
        end
      end
      ebcit_pkg::EBCIT_EXEC: begin
        if (last) begin
          state_d = ebcit_pkg::EBCIT_IDLE;
        end
      end
      default: state_d = ebcit_pkg::EBCIT_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ebcit_pkg::EBCIT_IDLE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  assign busy = (state_q == ebcit_pkg::EBCIT_EXEC);

  // ----------------------------------------------------------------
  // Instruction outputs, registered except for the clk_en gate on instr_done
  // ----------------------------------------------------------------
  logic done_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      done_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= last;
    end
  end
  assign instr_done = done_q && clk_en;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      instr_bytes <= 2'h0;
      instr_cycles <= '0;
      external_data_move <= 1'b0;
      code_byte_move <= 1'b0;
    end else if (clk_en && take) begin
      instr_bytes <= len;
      instr_cycles <= cyc_d;
      external_data_move <= (cls_d == ebcit_pkg::EBCIT_CLS_XDATA);
      code_byte_move <= (cls_d == ebcit_pkg::EBCIT_CLS_CODE);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cycle_index <= '0;
    end else if (clk_en) begin
      if (take) begin
        cycle_index <= '0;
      end else if (busy) begin
        cycle_index <= cycle_index + CYC_W'(1);
      end
    end
  end
endmodule

// >>> inc/ebcit_consts.svh
// Constants for the instruction timing decoder: counter width and cycle counts.
// Assumes inclusion by bare name from design files.
`ifndef EBCIT_CONSTS_SVH
`define EBCIT_CONSTS_SVH
`define EBCIT_CYC_W 4
`define EBCIT_CYC_MAX 4'h8
`define EBCIT_CYC_MUL 4'h4
`define EBCIT_CYC_DIV 4'h8
`define EBCIT_CYC_CODE 4'h3
`define EBCIT_CYC_XDATA 4'h3
`define EBCIT_CYC_IND 4'h2
`define EBCIT_CYC_RET 4'h5
`endif

// >>> inc/ebcit_pkg.sv
// Types shared by the instruction timing decoder.
// Assumes nothing of its surroundings.
package ebcit_pkg;
  typedef enum logic [2:0] {
    EBCIT_IDLE = 3'b001,
    EBCIT_EXEC = 3'b010,
    EBCIT_DONE = 3'b100
  } ebcit_state_e;
  typedef enum logic [2:0] {
    EBCIT_CLS_PLAIN = 3'h0,
    EBCIT_CLS_COND  = 3'h1,
    EBCIT_CLS_XDATA = 3'h2,
    EBCIT_CLS_CODE  = 3'h3,
    EBCIT_CLS_MULDIV = 3'h4,
    EBCIT_CLS_JUMP  = 3'h5
  } ebcit_class_e;
endpackage

// >>> hw/ebcit_length.sv
// Opcode byte length table.
// Assumes opcode presented combinationally.
`timescale 1ns/10ps
`include "ebcit_consts.svh"
module ebcit_length (
  input wire logic [7:0] opcode,
  output logic [1:0] length
);
  logic [3:0] lo;
  assign lo = opcode[3:0];
  always_comb begin
    length = 2'h1;
    if (lo >= 4'h8) begin
      // Register bank forms are one byte, except the few with an operand.
      case (opcode[7:4])
        4'h7, 4'h8, 4'ha: length = 2'h2;
        4'hb, 4'hd: length = (opcode[7:4] == 4'hb) ? 2'h3 : 2'h2;
        default: length = 2'h1;
      endcase
    end else if (lo == 4'h6 || lo == 4'h7) begin
      case (opcode[7:4])
        4'h7, 4'h8, 4'ha: length = 2'h2;
        4'hb: length = 2'h3;
        default: length = 2'h1;
      endcase
    end else if (lo == 4'h1) begin
      length = 2'h2;
    end else if (lo == 4'h5) begin
      case (opcode[7:4])
        4'h8, 4'hd: length = 2'h3;
        4'ha: length = 2'h1;
        4'he, 4'hf: length = 2'h2;
        default: length = 2'h2;
      endcase
      if (opcode == 8'h75 || opcode == 8'h85 || opcode == 8'hb5 || opcode == 8'hd5) begin
        length = 2'h3;
      end
    end else if (lo == 4'h4) begin
      case (opcode[7:4])
        4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9: length = 2'h2;
        4'hb: length = 2'h3;
        default: length = 2'h1;
      endcase
    end else if (lo == 4'h3) begin
      // Only the logic immediate into direct byte forms carry two operand bytes here.
      case (opcode[7:4])
        4'h4, 4'h5, 4'h6: length = 2'h3;
        default: length = 2'h1;
      endcase
    end else if (lo == 4'h2) begin
      case (opcode[7:4])
        4'h2, 4'h3: length = 2'h1;
        4'he, 4'hf: length = 2'h1;
        default: length = 2'h2;
      endcase
      if (opcode == 8'h02 || opcode == 8'h12) begin
        length = 2'h3;
      end
    end else if (lo == 4'h0) begin
      length = (opcode == 8'h00 || opcode[7:4] >= 4'he) ? 2'h1 : 2'h2;
      if (opcode == 8'h10 || opcode == 8'h20 || opcode == 8'h30 || opcode == 8'h90) begin
        length = 2'h3;
      end
      if (opcode == 8'he0 || opcode == 8'hf0) begin
        length = 2'h1;
      end
      if (opcode == 8'hd0 || opcode == 8'hc0) begin
        length = 2'h2;
      end
    end
  end
endmodule

// >>> hw/ebcit_counter.sv
// Down counter that marks the last cycle of an instruction.
// Assumes load and enable synchronous to clk_sys.
`timescale 1ns/10ps
`include "ebcit_consts.svh"
module ebcit_counter #(
  parameter int CYC_W = `EBCIT_CYC_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [CYC_W-1:0] cycles,
  output logic last
);
  logic [CYC_W-1:0] remain_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      remain_q <= '0;
    end else if (clk_en) begin
      if (load) begin
        remain_q <= cycles - CYC_W'(1);
      end else if (remain_q != '0) begin
        remain_q <= remain_q - CYC_W'(1);
      end
    end
  end
  assign last = (remain_q == CYC_W'(1)) || (load && cycles == CYC_W'(1));
endmodule

// >>> testbench/ebcit_properties.sv
// Timing checker for the instruction decoder.
// Assumes it is bound to ebcit_timing with all ports visible.
`timescale 1ns/10ps
module ebcit_properties (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire logic [7:0] opcode,
  input wire logic branch_taken,
  input wire logic op_ready,
  input wire logic [1:0] instr_bytes,
  input wire logic [3:0] instr_cycles,
  input wire logic instr_done,
  input wire logic external_data_move,
  input wire logic code_byte_move
);
  logic take;
  assign take = clk_en && op_valid && op_ready;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  mul_timing_a: assert property (take && opcode == 8'ha4 |=>
    instr_cycles == 4'h4 ##3 instr_done) else $error("multiply timing wrong");
  cycle_cap_a: assert property (take |=> instr_cycles inside {[4'h1:4'h8]})
    else $error("cycle count out of range");
  code_move_a: assert property (take && opcode inside {8'h93, 8'h83} |=>
    code_byte_move && instr_cycles == 4'h3 && instr_bytes == 2'h1) else $error("code move wrong");
  xdata_move_a: assert property (take && opcode inside {8'he0, 8'he2, 8'hf0, 8'hf2} |=>
    external_data_move && instr_cycles == 4'h3 ##2 instr_done) else $error("xdata move wrong");
  branch_time_a: assert property (take && opcode == 8'h40 |=>
    instr_cycles == ($past(branch_taken) ? 4'h3 : 4'h2)) else $error("branch time wrong");
  single_cycle_a: assert property (take && opcode inside {8'h98, 8'ha3, 8'h33} |=>
    instr_cycles == 4'h1 && instr_done) else $error("single cycle op wrong");
  indirect_alu_a: assert property (take && opcode == 8'h26 |=>
    instr_cycles == 4'h2 ##1 instr_done) else $error("indirect alu timing wrong");
  three_byte_a: assert property (take && opcode inside {8'h53, 8'h85, 8'h90} |=>
    instr_bytes == 2'h3 && instr_cycles == 4'h3) else $error("three byte op wrong");
  refuse_busy_a: assert property (clk_en && op_valid && !op_ready |=>
    $stable(instr_cycles) && $stable(instr_bytes)) else $error("busy request accepted");
  cover property (take && opcode == 8'h84);
  cover property (op_valid && !op_ready);
  cover property (!clk_en && !op_ready);
endmodule
bind ebcit_timing ebcit_properties ebcit_properties_i (.clk_sys(clk_sys), .reset_n(reset_n),
  .clk_en(clk_en), .op_valid(op_valid), .opcode(opcode), .branch_taken(branch_taken),
  .op_ready(op_ready), .instr_bytes(instr_bytes), .instr_cycles(instr_cycles),
  .instr_done(instr_done), .external_data_move(external_data_move),
  .code_byte_move(code_byte_move));

// >>> testbench/ebcit_prog_mem.sv
// Program memory model that offers one opcode at a time.
// Assumes a one-cycle req from the bench; holds the offer until taken.
`timescale 1ns/10ps
module ebcit_prog_mem (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic op_ready,
  input wire logic req,
  input wire logic [7:0] req_op,
  input wire logic req_br,
  output logic op_valid,
  output logic [7:0] opcode,
  output logic branch_taken,
  output logic taken
);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      op_valid <= 1'b0;
      opcode <= 8'h00;
      branch_taken <= 1'b0;
      taken <= 1'b0;
    end else begin
      taken <= op_valid && op_ready && clk_en;
      if (req) begin
        op_valid <= 1'b1;
        opcode <= req_op;
        branch_taken <= req_br;
      end else if (op_valid && op_ready && clk_en) begin
        op_valid <= 1'b0;
        opcode <= ~opcode;
        branch_taken <= ~branch_taken;
      end
    end
  end
endmodule

// >>> testbench/eight_bit_core_instruction_timing_bench.sv
// Self-checking bench for the instruction timing decoder.
// Assumes a 10 MHz clock and the program memory model on the opcode side.
`timescale 1ns/10ps
module eight_bit_core_instruction_timing_bench;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic req = 1'b0;
  logic [7:0] req_op = 8'h00;
  logic req_br = 1'b0;
  logic op_valid, branch_taken, taken, op_ready, busy, instr_done, xdm, cbm;
  logic [7:0] opcode;
  logic [1:0] instr_bytes;
  logic [3:0] instr_cycles;
  logic [3:0] cycle_index;
  int fail_count = 0;
  int checks = 0;
  always #50 clk_sys = ~clk_sys;
  ebcit_timing ebcit_timing_i (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .op_valid(op_valid), .opcode(opcode), .branch_taken(branch_taken), .op_ready(op_ready),
    .busy(busy), .instr_done(instr_done), .instr_bytes(instr_bytes),
    .instr_cycles(instr_cycles), .cycle_index(cycle_index), .external_data_move(xdm),
    .code_byte_move(cbm));
  ebcit_prog_mem ebcit_prog_mem_i (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .op_ready(op_ready), .req(req), .req_op(req_op), .req_br(req_br), .op_valid(op_valid),
    .opcode(opcode), .branch_taken(branch_taken), .taken(taken));
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic issue(logic [7:0] op, logic br);
    @(posedge clk_sys);
    req <= 1'b1;
    req_op <= op;
    req_br <= br;
    @(posedge clk_sys);
    req <= 1'b0;
  endtask
  task automatic wait_take(output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (taken !== 1'b1 && n < 20);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic run_op(logic [7:0] op, logic br, logic [1:0] nb, logic [3:0] nc, bit stall);
    int n;
    issue(op, br);
    wait_take(n);
    check("bytes", {6'h00, instr_bytes}, {6'h00, nb});
    check("cycles", {4'h0, instr_cycles}, {4'h0, nc});
    check("taken", {7'h00, taken}, 8'h01);
    check("ready early", {7'h00, op_ready}, {7'h00, nc == 4'h1});
    n = 1;
    if (stall) begin
      @(posedge clk_sys);
      clk_en <= 1'b0;
      repeat (3) @(posedge clk_sys);
      clk_en <= 1'b1;
      @(negedge clk_sys);
      check("busy frozen", {7'h00, busy}, 8'h01);
      n = 5;
    end
    while (instr_done !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    check("done cycle", n[7:0], {4'h0, nc} + (stall ? 8'h03 : 8'h00));
    check("ready at done", {7'h00, op_ready}, 8'h01);
    check("cycle index", {4'h0, cycle_index}, {4'h0, nc} - 8'h01);
  endtask
  task automatic test_alu();
    run_op(8'h26, 1'b0, 2'h1, 4'h2, 1'b0);
    run_op(8'h98, 1'b0, 2'h1, 4'h1, 1'b0);
    run_op(8'h53, 1'b0, 2'h3, 4'h3, 1'b0);
    run_op(8'ha3, 1'b0, 2'h1, 4'h1, 1'b0);
    run_op(8'h33, 1'b0, 2'h1, 4'h1, 1'b0);
    run_op(8'h13, 1'b0, 2'h1, 4'h1, 1'b0);
    run_op(8'ha4, 1'b0, 2'h1, 4'h4, 1'b0);
    run_op(8'h84, 1'b0, 2'h1, 4'h8, 1'b0);
    $display("test alu done");
  endtask
  task automatic test_moves();
    logic [7:0] xops[4] = '{8'he0, 8'he2, 8'hf0, 8'hf2};
    run_op(8'h85, 1'b0, 2'h3, 4'h3, 1'b0);
    run_op(8'h76, 1'b0, 2'h2, 4'h2, 1'b0);
    run_op(8'h90, 1'b0, 2'h3, 4'h3, 1'b0);
    run_op(8'h93, 1'b0, 2'h1, 4'h3, 1'b0);
    run_op(8'h83, 1'b0, 2'h1, 4'h3, 1'b0);
    check("code flag", {7'h00, cbm}, 8'h01);
    foreach (xops[i]) run_op(xops[i], 1'b0, 2'h1, 4'h3, 1'b0);
    check("xdata flag", {7'h00, xdm}, 8'h01);
    run_op(8'hc0, 1'b0, 2'h2, 4'h2, 1'b0);
    run_op(8'hd0, 1'b0, 2'h2, 4'h2, 1'b0);
    run_op(8'hd6, 1'b0, 2'h1, 4'h2, 1'b0);
    check("code flag clear", {7'h00, cbm}, 8'h00);
    check("xdata flag clear", {7'h00, xdm}, 8'h00);
    $display("test moves done");
  endtask
  task automatic test_bits_branch();
    run_op(8'hb2, 1'b0, 2'h2, 4'h2, 1'b0);
    run_op(8'hd2, 1'b0, 2'h2, 4'h2, 1'b0);
    run_op(8'hc2, 1'b0, 2'h2, 4'h2, 1'b0);
    run_op(8'h82, 1'b0, 2'h2, 4'h2, 1'b0);
    run_op(8'h72, 1'b0, 2'h2, 4'h2, 1'b0);
    run_op(8'h40, 1'b1, 2'h2, 4'h3, 1'b0);
    run_op(8'h40, 1'b0, 2'h2, 4'h2, 1'b0);
    $display("test bits and branch done");
  endtask
  task automatic test_refuse_freeze();
    int n;
    issue(8'h84, 1'b0);
    wait_take(n);
    issue(8'h98, 1'b0);
    wait_take(n);
    check("late take", n[7:0], 8'h07);
    check("next cycles", {4'h0, instr_cycles}, 8'h01);
    run_op(8'h84, 1'b0, 2'h1, 4'h8, 1'b1);
    $display("test refuse and freeze done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    test_alu();
    test_moves();
    test_bits_branch();
    test_refuse_freeze();
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    finish_test();
  end
endmodule
